// >>> idt_params.svh
// Constants for the instruction decode and timing block: field positions,
// opcode map boundaries and cycle counts. Included by the package and every module file.
`ifndef IDT_PARAMS_SVH
`define IDT_PARAMS_SVH

`define IDT_WORD_W      24
`define IDT_OPC_W       8
`define IDT_OPC_HI      23
`define IDT_OPC_LO      16
`define IDT_REG_W       4
`define IDT_CYC_W       2
`define IDT_CYC_ONE     2'h1
`define IDT_CYC_TWO     2'h2
`define IDT_CYC_THREE   2'h3
`define IDT_SECOND_TOP  8'h00
`define IDT_WORKING_DEST 4'h0
`define IDT_AWB_REG     4'hD
`define IDT_PAIR_BASE   2'b01
`define IDT_PAIR_LAST   3'h5
// Opcode map: inclusive ranges
`define IDT_OP_NOP      8'h00
`define IDT_OP_BRA      8'h01
`define IDT_OP_RET_LO   8'h04
`define IDT_OP_RET_HI   8'h05
`define IDT_OP_TBL_HI   8'h07
`define IDT_OP_DBL_LO   8'h08
`define IDT_OP_DBL_PC   8'h09
`define IDT_OP_DBL_HI   8'h0A
`define IDT_OP_CND_HI   8'h0F
`define IDT_OP_BIT_HI   8'h1F
`define IDT_OP_SKP_LO   8'h18
`define IDT_OP_SKP_HI   8'h1B
`define IDT_OP_LIT_HI   8'h3F
`define IDT_OP_WRD_HI   8'h6F
`define IDT_OP_FIL_HI   8'h7F
`define IDT_OP_MOV_LO   8'h80
`define IDT_OP_DMV_HI   8'h81
`define IDT_OP_MOV_HI   8'h8F
`define IDT_OP_MAC_LO   8'hC0
`define IDT_OP_MAC_HI   8'hCF
`define IDT_OP_DSP_HI   8'hDF

`endif

// >>> idt_pkg.sv
// Types shared by the decoder and its attribute table.
// Assumes idt_params.svh is on the include path.
`include "idt_params.svh"

package idt_pkg;
  typedef enum logic [2:0] {
    CLS_NONE, CLS_WORD, CLS_FILE, CLS_BIT, CLS_LIT, CLS_MAC, CLS_DSP, CLS_CTRL
  } idt_class_t;

  typedef enum logic [1:0] {AWB_NONE, AWB_REG, AWB_POSTINC} idt_awb_t;

  typedef struct packed {
    idt_class_t               cls;
    logic                     two_word;
    logic                     pc_change;
    logic                     cond;
    logic                     skip;
    logic                     dword;
    logic [`IDT_CYC_W-1:0]    base_cyc;
    logic                     legal;
  } idt_attr_t;

  typedef struct packed {
    idt_class_t               cls;
    logic [`IDT_OPC_W-1:0]    opcode;
    logic                     two_word;
    logic [`IDT_REG_W-1:0]    base_operand_reg;
    logic [`IDT_REG_W-1:0]    source_operand_reg;
    logic [1:0]               src_mode;
    logic [`IDT_REG_W-1:0]    dest_operand_reg;
    logic [1:0]               dst_mode;
    logic [12:0]              file_addr;
    logic                     dest_is_file;
    logic [3:0]               bit_pos;
    logic                     bit_indirect;
    logic [7:0]               literal;
    logic                     acc_b;
    logic [`IDT_REG_W-1:0]    mul_m;
    logic [`IDT_REG_W-1:0]    mul_n;
    logic                     pair_ok;
    logic [`IDT_REG_W-1:0]    x_dest;
    logic [`IDT_REG_W-1:0]    y_dest;
    idt_awb_t                 accumulator_writeback_target;
    logic [`IDT_REG_W-1:0]    shift_count_reg;
    logic [5:0]               shift_lit;
    logic                     shift_is_lit;
    logic [1:0]               tbl_mode;
    logic [22:0]              prog_addr;
  } idt_dec_t;
endpackage

// >>> idt_attr_rom.sv
// Opcode attribute table: class, length and timing per 8-bit opcode.
// Read data is registered; the decoder reads it one clock after the address.
`timescale 1ns/10ps
`default_nettype none
`include "idt_params.svh"

module idt_attr_rom import idt_pkg::*; (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // Read port
  input  wire logic [`IDT_OPC_W-1:0] rd_addr,
  output var  idt_attr_t             rd_q
);

  function automatic idt_attr_t attr_of(input logic [`IDT_OPC_W-1:0] op);
    idt_attr_t a;
    a = '{cls: CLS_NONE, two_word: 1'b0, pc_change: 1'b0, cond: 1'b0, skip: 1'b0,
          dword: 1'b0, base_cyc: `IDT_CYC_ONE, legal: 1'b1};
    if (op == `IDT_OP_NOP) begin
      a.cls = CLS_NONE;
    end else if (op <= `IDT_OP_TBL_HI) begin
      // Branch, indirect call/jump, returns, table access: multi-cycle singles
      a.cls       = CLS_CTRL;
      a.pc_change = (op <= `IDT_OP_RET_HI);
      a.base_cyc  = (op >= `IDT_OP_RET_LO && op <= `IDT_OP_RET_HI) ?
                    `IDT_CYC_THREE : `IDT_CYC_TWO;
    end else if (op <= `IDT_OP_DBL_HI) begin
      a.cls       = CLS_CTRL;
      a.two_word  = 1'b1;
      a.pc_change = (op <= `IDT_OP_DBL_PC);
    end else if (op <= `IDT_OP_CND_HI) begin
      a.cls       = CLS_CTRL;
      a.cond      = 1'b1;
      a.pc_change = 1'b1;
    end else if (op <= `IDT_OP_BIT_HI) begin
      a.cls  = CLS_BIT;
      a.skip = (op >= `IDT_OP_SKP_LO && op <= `IDT_OP_SKP_HI);
    end else if (op <= `IDT_OP_LIT_HI) begin
      a.cls = CLS_LIT;
    end else if (op <= `IDT_OP_WRD_HI) begin
      a.cls = CLS_WORD;
    end else if (op <= `IDT_OP_FIL_HI) begin
      a.cls = CLS_FILE;
    end else if (op >= `IDT_OP_MOV_LO && op <= `IDT_OP_MOV_HI) begin
      a.cls   = CLS_WORD;
      a.dword = (op <= `IDT_OP_DMV_HI);
    end else if (op >= `IDT_OP_MAC_LO && op <= `IDT_OP_MAC_HI) begin
      a.cls = CLS_MAC;
    end else if (op > `IDT_OP_MAC_HI && op <= `IDT_OP_DSP_HI) begin
      a.cls = CLS_DSP;
    end else begin
      a.legal = 1'b0;
    end
    return a;
  endfunction

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_q <= attr_of(`IDT_OP_NOP);
    end else begin
      rd_q <= attr_of(rd_addr);
    end
  end

endmodule // idt_attr_rom

`default_nettype wire

// >>> idt_decoder.sv
// Instruction fetch/decode and cycle accounting for 24-bit program words.
// Assumes a program memory source on the same clock with valid/ready.
//
// Behaviour
// - Each program location is one 24-bit instruction word.
// - Single-word instruction has an 8-bit opcode plus operand fields.
// - Exactly three instructions take two locations; all others one.
// - Two-word instruction spans 48 bits; second word top byte is zero.
// - A lone second word executes as a no-operation.
// - Plain single-word instruction finishes in one instruction cycle.
// - True condition or program counter change costs two cycles.
// - Branch, indirect call/jump, table access, returns take two or three.
// - Taken skip costs two cycles, or three over a two-word instruction.
// - Double-width data moves take two cycles.
// - Two-location instructions complete in two cycles.
// - Seven instruction classes are recognised.
// - Working-register ops decode base, source and destination with modes.
// - File ops decode file address and destination file or W0.
// - Bit ops name register and bit from literal or base register.
// - Literal ops use base plus literal; separate destination optional.
// - Multiply class names accumulator, pair, prefetch dests, write-back.
// - Other signal ops name accumulator, operand, shift from reg or literal.
// - Control ops decode program address and table access mode.
// - Working-register fields select registers zero to fifteen.
// - Multiply pairs are distinct pairings from registers four to seven.
// - Write-back target is register thirteen or its post-increment memory.
// - Prefetch destination is one of registers four to seven.
`timescale 1ns/10ps
`default_nettype none
`include "idt_params.svh"

module idt_decoder import idt_pkg::*; (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Program word stream
  input  wire logic                   instr_valid,
  input  wire logic [`IDT_WORD_W-1:0] instr_word,
  output logic                        instr_ready,
  // Condition result from execute
  input  wire logic                   cond_true,
  // Decode results
  output var  logic                   dec_valid_q,
  output var  idt_dec_t               dec_q,
  output var  logic                   inst_done_q,
  output var  logic [`IDT_CYC_W-1:0]  inst_cycles_q,
  output var  logic                   nop_cycle_q,
  output var  logic                   second_word_err_q,
  output var  logic                   illegal_op_q
);

  typedef enum logic [2:0] {
    ST_FETCH, ST_CLASS, ST_SECOND, ST_NOP, ST_SKIP, ST_SKIP_CLASS, ST_SKIP_SECOND
  } idt_state_t;

  idt_state_t              state_q;
  logic [`IDT_WORD_W-1:0]  word_q;
  logic [`IDT_CYC_W-1:0]   nop_left_q;
  logic [`IDT_OPC_W-1:0]   rom_addr;
  idt_attr_t               attr;
  logic                    accept;
  logic                    skip_go;
  logic [`IDT_CYC_W-1:0]   cyc_n;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [`IDT_OPC_W-1:0] opc(input logic [`IDT_WORD_W-1:0] w);
    return w[`IDT_OPC_HI:`IDT_OPC_LO];
  endfunction

  // Cycles of a non-skip single-word instruction
  function automatic logic [`IDT_CYC_W-1:0] cyc_of(input idt_attr_t a, input logic c);
    if (a.base_cyc != `IDT_CYC_ONE) begin
      return a.base_cyc;
    end else if (a.dword) begin
      return `IDT_CYC_TWO;
    end else if (a.cond && c) begin
      return `IDT_CYC_TWO;
    end else if (a.pc_change && !a.cond) begin
      return `IDT_CYC_TWO;
    end
    return `IDT_CYC_ONE;
  endfunction

  // Pair code 0..5 maps to the six distinct pairings of W4..W7
  function automatic logic [3:0] pair_of(input logic [2:0] code);
    case (code)
      3'h0:    return 4'b00_01;
      3'h1:    return 4'b00_10;
      3'h2:    return 4'b00_11;
      3'h3:    return 4'b01_10;
      3'h4:    return 4'b01_11;
      3'h5:    return 4'b10_11;
      default: return 4'b00_01;
    endcase
  endfunction

  function automatic idt_dec_t decode(input idt_attr_t a,
                                      input logic [`IDT_WORD_W-1:0] w,
                                      input logic [`IDT_WORD_W-1:0] x);
    idt_dec_t   d;
    logic [3:0] pr;
    d          = '0;
    pr         = pair_of(w[14:12]);
    d.cls      = a.cls;
    d.opcode   = opc(w);
    d.two_word = a.two_word;
    case (a.cls)
      CLS_WORD: begin
        d.base_operand_reg   = w[15:12];
        d.dst_mode           = w[11:10];
        d.dest_operand_reg   = w[9:6];
        d.src_mode           = w[5:4];
        d.source_operand_reg = w[3:0];
      end
      CLS_FILE: begin
        d.file_addr    = w[12:0];
        d.dest_is_file = w[13];
        d.dest_operand_reg = w[13] ? 4'h0 : `IDT_WORKING_DEST;
      end
      CLS_BIT: begin
        if (d.opcode[0]) begin
          // File target: bit position only from the literal
          d.file_addr = {1'b0, w[11:0]};
          d.bit_pos   = w[15:12];
        end else begin
          d.bit_indirect       = w[11];
          d.base_operand_reg   = w[11] ? w[15:12] : 4'h0;
          d.bit_pos            = w[11] ? 4'h0 : w[15:12];
          d.src_mode           = w[5:4];
          d.source_operand_reg = w[3:0];
        end
      end
      CLS_LIT: begin
        d.literal          = w[15:8];
        d.base_operand_reg = w[3:0];
        d.dest_operand_reg = d.opcode[0] ? w[7:4] : w[3:0];
      end
      CLS_MAC: begin
        d.acc_b   = w[15];
        d.pair_ok = (w[14:12] <= `IDT_PAIR_LAST);
        d.mul_m   = {`IDT_PAIR_BASE, pr[3:2]};
        d.mul_n   = {`IDT_PAIR_BASE, pr[1:0]};
        d.x_dest  = {`IDT_PAIR_BASE, w[11:10]};
        d.y_dest  = {`IDT_PAIR_BASE, w[9:8]};
        case (w[1:0])
          2'h1:    d.accumulator_writeback_target = AWB_REG;
          2'h2:    d.accumulator_writeback_target = AWB_POSTINC;
          default: d.accumulator_writeback_target = AWB_NONE;
        endcase
        if (w[1:0] == 2'h1 || w[1:0] == 2'h2) begin
          d.dest_operand_reg = `IDT_AWB_REG;
        end
      end
      CLS_DSP: begin
        d.acc_b              = w[15];
        d.shift_is_lit       = w[14];
        d.shift_lit          = w[13:8];
        d.shift_count_reg    = w[11:8];
        d.src_mode           = w[5:4];
        d.source_operand_reg = w[3:0];
        d.dest_operand_reg   = w[3:0];
      end
      CLS_CTRL: begin
        d.tbl_mode  = w[15:14];
        // Long address: low 16 bits here, upper bits from the second word
        d.prog_addr = a.two_word ? {x[6:0], w[15:0]} : {7'h00, w[15:0]};
      end
      default: begin
        d.cls = CLS_NONE;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Handshake and attribute lookup
  // ----------------------------------------------------------------
  always_comb begin
    instr_ready = (state_q == ST_FETCH) || (state_q == ST_SECOND) ||
                  (state_q == ST_SKIP) || (state_q == ST_SKIP_SECOND);
    accept      = instr_valid && instr_ready;
    // Hold the first word's opcode so its attributes stay valid across
    // the wait for the second word
    rom_addr    = (state_q == ST_FETCH || state_q == ST_SKIP) ?
                  opc(instr_word) : opc(word_q);
    skip_go     = attr.skip && cond_true;
    cyc_n       = cyc_of(attr, cond_true);
  end

  idt_attr_rom u_attr_rom (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rd_addr  (rom_addr),
    .rd_q     (attr)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_FETCH;
    end else begin
      case (state_q)
        ST_FETCH: begin
          if (accept) state_q <= ST_CLASS;
        end
        ST_CLASS: begin
          if (!attr.legal) begin
            state_q <= ST_FETCH;
          end else if (attr.two_word) begin
            state_q <= ST_SECOND;
          end else if (skip_go) begin
            state_q <= ST_SKIP;
          end else if (cyc_n != `IDT_CYC_ONE) begin
            state_q <= ST_NOP;
          end else begin
            state_q <= ST_FETCH;
          end
        end
        ST_SECOND: begin
          if (accept) state_q <= ST_FETCH;
        end
        ST_NOP: begin
          if (nop_left_q == `IDT_CYC_ONE) state_q <= ST_FETCH;
        end
        ST_SKIP: begin
          if (accept) state_q <= ST_SKIP_CLASS;
        end
        ST_SKIP_CLASS: begin
          state_q <= attr.two_word ? ST_SKIP_SECOND : ST_FETCH;
        end
        ST_SKIP_SECOND: begin
          if (accept) state_q <= ST_FETCH;
        end
        default: state_q <= ST_FETCH;
      endcase
    end
  end

  // First word capture; skipped words are captured only to classify them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      word_q <= 24'h000000;
    end else if (accept && state_q != ST_SECOND && state_q != ST_SKIP_SECOND) begin
      word_q <= instr_word;
    end
  end

  // ----------------------------------------------------------------
  // Cycle accounting
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inst_cycles_q <= 2'h0;
      nop_left_q    <= 2'h0;
    end else begin
      case (state_q)
        ST_CLASS: begin
          inst_cycles_q <= `IDT_CYC_ONE;
          nop_left_q    <= cyc_n - `IDT_CYC_ONE;
        end
        ST_SECOND: begin
          if (accept) inst_cycles_q <= `IDT_CYC_TWO;
        end
        ST_NOP: begin
          inst_cycles_q <= inst_cycles_q + `IDT_CYC_ONE;
          nop_left_q    <= nop_left_q - `IDT_CYC_ONE;
        end
        ST_SKIP, ST_SKIP_SECOND: begin
          if (accept) inst_cycles_q <= inst_cycles_q + `IDT_CYC_ONE;
        end
        default: begin
          nop_left_q <= nop_left_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result pulses and decoded fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dec_valid_q <= 1'b0;
      dec_q       <= '0;
    end else begin
      dec_valid_q <= (state_q == ST_CLASS && attr.legal && !attr.two_word) ||
                     (state_q == ST_SECOND && accept);
      if (state_q == ST_CLASS && attr.legal && !attr.two_word) begin
        dec_q <= decode(attr, word_q, 24'h000000);
      end else if (state_q == ST_SECOND && accept) begin
        dec_q <= decode(attr, word_q, instr_word);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inst_done_q       <= 1'b0;
      nop_cycle_q       <= 1'b0;
      second_word_err_q <= 1'b0;
      illegal_op_q      <= 1'b0;
    end else begin
      inst_done_q <= (state_q == ST_CLASS && (!attr.legal || (!attr.two_word &&
                      !skip_go && cyc_n == `IDT_CYC_ONE))) ||
                     (state_q == ST_NOP && nop_left_q == `IDT_CYC_ONE) ||
                     (state_q == ST_SKIP_CLASS && !attr.two_word) ||
                     ((state_q == ST_SECOND || state_q == ST_SKIP_SECOND) && accept);
      // Extra cycles run as no-operations, including skipped words
      nop_cycle_q <= (state_q == ST_NOP) ||
                     ((state_q == ST_SKIP || state_q == ST_SKIP_SECOND) && accept);
      // A second word whose top byte is not zero is malformed
      second_word_err_q <= state_q == ST_SECOND && accept &&
                           opc(instr_word) != `IDT_SECOND_TOP;
      illegal_op_q <= state_q == ST_CLASS && !attr.legal;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_nop_tail_two;
    state_q == ST_NOP ##1 (inst_done_q && nop_cycle_q && inst_cycles_q == 2'h2);
  endsequence

  sequence s_nop_tail_three;
    state_q == ST_NOP ##1 (nop_cycle_q && !inst_done_q) ##1
    (inst_done_q && nop_cycle_q && inst_cycles_q == 2'h3);
  endsequence

  logic plain_single;
  assign plain_single = state_q == ST_CLASS && attr.legal && !attr.two_word &&
                        !attr.skip && !attr.dword && !attr.pc_change &&
                        attr.base_cyc == 2'h1;

  a_ready_in_fetch: assert property (
    state_q == ST_FETCH |-> instr_ready) else $error("not ready in fetch");

  a_opcode_field: assert property (
    plain_single |=> dec_valid_q && dec_q.opcode == $past(word_q[23:16]))
    else $error("opcode not from top byte");

  a_single_cycle: assert property (
    plain_single |=> inst_done_q && inst_cycles_q == 2'h1 && !nop_cycle_q)
    else $error("plain instruction not one cycle");

  a_cond_true_two: assert property (
    state_q == ST_CLASS && attr.legal && attr.cond && cond_true |=> s_nop_tail_two)
    else $error("true condition not two cycles");

  a_slow_three: assert property (
    state_q == ST_CLASS && attr.legal && attr.base_cyc == 2'h3 |=> s_nop_tail_three)
    else $error("return not three cycles");

  a_skip_one_word: assert property (
    state_q == ST_SKIP_CLASS && !attr.two_word |=> inst_done_q && inst_cycles_q == 2'h2)
    else $error("skip over one word not two cycles");

  a_skip_two_word: assert property (
    state_q == ST_SKIP_SECOND && accept |=> inst_done_q && inst_cycles_q == 2'h3)
    else $error("skip over two words not three cycles");

  a_dword_move: assert property (
    state_q == ST_CLASS && attr.legal && attr.dword |=> s_nop_tail_two)
    else $error("double move not two cycles");

  a_two_word_done: assert property (
    state_q == ST_SECOND && accept |=> inst_done_q && dec_valid_q &&
    dec_q.two_word && inst_cycles_q == 2'h2) else $error("two-word not two cycles");

  a_second_top_zero: assert property (
    state_q == ST_SECOND && accept && instr_word[23:16] != 8'h00 |=> second_word_err_q)
    else $error("bad second word not flagged");

  a_lone_second_nop: assert property (
    state_q == ST_FETCH && accept && instr_word[23:16] == 8'h00 |=> ##1
    dec_valid_q && dec_q.cls == CLS_NONE && inst_cycles_q == 2'h1)
    else $error("lone second word not a no-operation");

  a_file_default_dest: assert property (
    dec_valid_q && dec_q.cls == CLS_FILE && !dec_q.dest_is_file |->
    dec_q.dest_operand_reg == 4'h0) else $error("file result not to W0");

  a_mac_pair_range: assert property (
    dec_valid_q && dec_q.cls == CLS_MAC |-> dec_q.mul_m >= 4'h4 &&
    dec_q.mul_m < dec_q.mul_n && dec_q.mul_n <= 4'h7 && dec_q.x_dest[3:2] == 2'b01)
    else $error("multiply pair or prefetch dest out of range");

endmodule // idt_decoder

`default_nettype wire

// >>> idt_prog_mem.sv
// Program memory model: serves queued 24-bit words on valid/ready.
// Assumes the decoder samples its inputs on the rising core_clk edge.
`timescale 1ns/10ps
`default_nettype none
`include "idt_params.svh"
module idt_prog_mem (
  // Clock, reset and stall
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 slow,
  // Word stream
  input  wire logic                 instr_ready,
  output logic                      instr_valid,
  output logic [`IDT_WORD_W-1:0]    instr_word
);
  logic [`IDT_WORD_W-1:0] q[$];
  logic                   taken;
  task automatic push(input logic [`IDT_WORD_W-1:0] w);
    q.push_back(w);
  endtask
  initial begin
    instr_valid = 1'b0;
    instr_word  = 24'h000000;
    taken       = 1'b0;
  end
  always @(posedge core_clk) taken <= instr_valid && instr_ready;
  // Idle bus inverts the shown word on each idle cycle, alternating between the last word and its inverse
  always @(negedge core_clk) begin
    if (taken) void'(q.pop_front());
    if (!rst_n) instr_valid = 1'b0;
    else if (instr_valid && !taken) instr_valid = 1'b1;
    else if (q.size() != 0 && !slow) begin
      instr_valid = 1'b1;
      instr_word  = q[0];
    end else begin
      instr_valid = 1'b0;
      instr_word  = ~instr_word;
    end
  end
endmodule // idt_prog_mem
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for idt_decoder fed by a program memory model.
// Assumes idt_pkg and idt_prog_mem are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "idt_params.svh"
module testbench;
  import idt_pkg::*;
  logic        core_clk, rst_n, slow, cond_true, instr_valid, instr_ready;
  logic [23:0] instr_word, w;
  logic        dec_valid_q, inst_done_q, nop_cycle_q, second_word_err_q, illegal_op_q;
  idt_dec_t    dec_q;
  logic [1:0]  inst_cycles_q;
  logic [31:0] seed, stall_s, n_fail, total_checks;
  int          n_nop, n_err, n_dv, n_ill, i;
  logic [7:0]  ops[10] = '{8'h01, 8'h04, 8'h06, 8'h07, 8'h0B, 8'h80, 8'h81, 8'h00, 8'h18, 8'hF0};
  idt_decoder u_idt_decoder (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .cond_true(cond_true),
    .dec_valid_q(dec_valid_q), .dec_q(dec_q), .inst_done_q(inst_done_q),
    .inst_cycles_q(inst_cycles_q), .nop_cycle_q(nop_cycle_q),
    .second_word_err_q(second_word_err_q), .illegal_op_q(illegal_op_q));
  idt_prog_mem u_idt_prog_mem (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
    .instr_ready(instr_ready), .instr_valid(instr_valid), .instr_word(instr_word));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic two(input logic [7:0] op);
    return op >= 8'h08 && op <= 8'h0A;
  endfunction
  // Opcodes outside the map: no decode, one cycle, flagged
  function automatic logic bad(input logic [7:0] op);
    return (op >= 8'h90 && op <= 8'hBF) || op >= 8'hE0;
  endfunction
  function automatic logic [1:0] exp_cyc(input logic [7:0] op, input logic c, input logic [7:0] nx);
    if (op == 8'h04 || op == 8'h05) return 2'h3;
    if (op >= 8'h18 && op <= 8'h1B && c) return two(nx) ? 2'h3 : 2'h2;
    if ((op >= 8'h01 && op <= 8'h0A) || op == 8'h80 || op == 8'h81) return 2'h2;
    if (op >= 8'h0B && op <= 8'h0F && c) return 2'h2;
    return 2'h1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks += 1;
    if (got !== exp) begin
      n_fail += 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks != 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One instruction: queue its words, wait for completion, check timing
  task automatic run(input logic [23:0] a, b, x, input int n, input logic cnd);
    int k;
    logic [1:0] ec;
    ec = exp_cyc(a[23:16], cnd, b[23:16]);
    @(negedge core_clk);
    cond_true = cnd;
    u_idt_prog_mem.push(a);
    if (n > 1) u_idt_prog_mem.push(b);
    if (n > 2) u_idt_prog_mem.push(x);
    n_nop = 0;
    n_err = 0;
    n_dv  = 0;
    n_ill = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      #1;
      n_nop += (nop_cycle_q === 1'b1);
      n_err += (second_word_err_q === 1'b1);
      n_dv  += (dec_valid_q === 1'b1);
      n_ill += (illegal_op_q === 1'b1);
      if (inst_done_q === 1'b1) break;
    end
    chk(inst_done_q, 1'b1);
    chk(inst_cycles_q, ec);
    chk(n_nop, two(a[23:16]) ? 0 : ec - 1);
    chk(n_err, two(a[23:16]) && b[23:16] != 8'h00);
    chk(n_dv, !bad(a[23:16]));
    chk(n_ill, bad(a[23:16]));
    $display("test %h done", a);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Random stalls make the memory answer promptly or slowly
  always @(negedge core_clk) begin
    stall_s = xs(stall_s);
    slow <= stall_s[1] & stall_s[2];
  end
  initial begin
    #400000;
    n_fail += 1;
    report_and_stop();
  end
  initial begin
    {rst_n, slow, cond_true, n_fail, total_checks, w} = '0;
    seed = 32'h4E540F16;
    stall_s = 32'h4E540F16;
    repeat (8) @(posedge core_clk);
    #1;
    chk(inst_cycles_q, 2'h0);
    chk(dec_valid_q, 1'b0);
    @(negedge core_clk);
    rst_n = 1'b1;
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      w = {8'h40, seed[15:0]};
      run(w, 24'h0, 24'h0, 1, seed[16]);
      chk(dec_q.cls, CLS_WORD);
      chk(dec_q.opcode, w[23:16]);
      chk(dec_q.base_operand_reg, w[15:12]);
      chk(dec_q.dest_operand_reg, w[9:6]);
      chk(dec_q.source_operand_reg, w[3:0]);
      w = {8'h70, seed[31:16]};
      run(w, 24'h0, 24'h0, 1, 1'b0);
      chk(dec_q.file_addr, w[12:0]);
      chk(dec_q.dest_is_file, w[13]);
      w = {8'hD0, seed[15:0]};
      run(w, 24'h0, 24'h0, 1, 1'b0);
      chk(dec_q.acc_b, w[15]);
      chk(dec_q.shift_is_lit, w[14]);
      if (w[14]) chk(dec_q.shift_lit, w[13:8]);
      else chk(dec_q.shift_count_reg, w[11:8]);
      w = {8'hC0, seed[15], 1'b0, seed[13:2], seed[1], ~seed[1]};
      run(w, 24'h0, 24'h0, 1, 1'b0);
      chk(dec_q.acc_b, w[15]);
      chk(dec_q.pair_ok, 1'b1);
      chk(dec_q.x_dest, {2'h1, w[11:10]});
      chk(dec_q.y_dest, {2'h1, w[9:8]});
      chk(dec_q.accumulator_writeback_target, w[1] ? AWB_POSTINC : AWB_REG);
      chk(dec_q.dest_operand_reg, 4'hD);
      run({8'h11, seed[15:0]}, 24'h0, 24'h0, 1, 1'b0);
      chk(dec_q.cls, CLS_BIT);
      chk(dec_q.bit_pos, seed[15:12]);
      run({8'h21, seed[15:0]}, 24'h0, 24'h0, 1, 1'b0);
      chk(dec_q.cls, CLS_LIT);
      chk(dec_q.literal, seed[15:8]);
      w = {8'h08 + 8'(i % 3), seed[15:0]};
      run(w, {17'h0, seed[22:16]}, 24'h0, 2, 1'b0);
      chk(dec_q.prog_addr, {seed[22:16], w[15:0]});
    end
    run(24'h090000, 24'h010000, 24'h0, 2, 1'b0);
    run(24'h180000, 24'h081234, 24'h000056, 3, 1'b1);
    run(24'h001234, 24'h0, 24'h0, 1, 1'b0);
    chk(dec_q.cls, CLS_NONE);
    for (i = 0; i < 20; i++) begin
      seed = xs(seed);
      run({ops[i / 2], seed[15:0]}, 24'h400000, 24'h0,
          (ops[i / 2] == 8'h18 && i[0]) ? 2 : 1, i[0]);
    end
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
